// ### bcc_boost_converter_control.sv
// boost converter control: registers, soft start, adaptive loop
// Operation
// - bit 3 switches active load
// - bit 2 selects adaptive regulation
// - bit 1 runs converter
// - bit 0 sets device active
// - switching cycles at one megahertz
// - manual target equals code in volts
// - codes below five use five
// - codes above twenty use twenty
// - enable low puts converter standby
// - enable high: 50 ms low current
// - adaptive mode ignores voltage code
// - below 30 mA: 0.85-1.35 V window
// - above 30 mA: 1.0-1.5 V window
// - adaptive target kept 5 to 20 V
// - adaptive selected after reset
// - stand-alone always adaptive
// - active load on: minimum pulse every cycle
// - no active load: pulse may end after one clock
// - overcurrent turns switch off
// - duty cycle limited digitally
// - broken feedback stops switching
// - enabled LED outputs from three bits
`timescale 1ns/10ps
module bcc_boost_converter_control (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        regWrite,
  input  wire logic [6:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  input  wire logic        standAlone,
  input  wire logic [2:0]  ledEnable,
  input  wire logic [2:0]  ledHighCurrent,
  input  wire logic [11:0] driverMv0,
  input  wire logic [11:0] driverMv1,
  input  wire logic [11:0] driverMv2,
  input  wire logic        feedbackSenseBelow,
  input  wire logic        feedbackBroken,
  input  wire logic        overCurrent,
  output logic             powerSwitchGate,
  output logic             activeLoadOn,
  output logic      [4:0]  targetVolts,
  output logic             softStartActive,
  output logic             converterRunning,
  output logic             deviceActive
);
  typedef struct packed {
    logic [7:0]             volt;
    logic [7:0]             ctrl;
    logic                   enPrev;
    bcc_pkg::bcc_state_t    st;
    logic [21:0]            softCnt;
    logic [9:0]             adjCnt;
    logic [4:0]             adaptV;
    logic [7:0]             rdata;
  } bcc_st_t;
  bcc_st_t s_r;
  bcc_st_t s_nxt;

  logic [11:0] lowMv;
  logic [11:0] winLo;
  logic [11:0] winHi;
  logic [7:0]  codeUsed;
  logic        adaptive;
  logic        running;
  logic        gate;
  logic        cycStart;
  logic [11:0] mv [3];

  assign mv[0] = driverMv0;
  assign mv[1] = driverMv1;
  assign mv[2] = driverMv2;

  always_comb begin
    lowMv = bcc_pkg::MV_MAX;
    for (int i = 0; i < 3; i++) begin
      if (ledEnable[i] && mv[i] < lowMv)
        lowMv = mv[i];
    end
  end

  always_comb begin
    s_nxt = s_r;
    if (s_r.volt < bcc_pkg::CODE_MIN)
      codeUsed = bcc_pkg::CODE_MIN;
    else if (s_r.volt > bcc_pkg::CODE_MAX)
      codeUsed = bcc_pkg::CODE_MAX;
    else
      codeUsed = s_r.volt;
    adaptive = s_r.ctrl[bcc_pkg::BIT_ADAPT] || standAlone;
    if (|(ledHighCurrent & ledEnable)) begin
      winLo = bcc_pkg::WIN_LO_HIGH;
      winHi = bcc_pkg::WIN_HI_HIGH;
    end else begin
      winLo = bcc_pkg::WIN_LO_LOW;
      winHi = bcc_pkg::WIN_HI_LOW;
    end
    if (regWrite && regAddr == bcc_pkg::ADDR_VOLT)
      s_nxt.volt = regWdata;
    if (regWrite && regAddr == bcc_pkg::ADDR_CTRL)
      s_nxt.ctrl = {4'h0, regWdata[3:0]};
    case (regAddr)
      bcc_pkg::ADDR_VOLT: s_nxt.rdata = s_r.volt;
      bcc_pkg::ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
      default:            s_nxt.rdata = 8'h00;
    endcase
    s_nxt.enPrev = s_r.ctrl[bcc_pkg::BIT_BOOST_EN];
    case (s_r.st)
      bcc_pkg::ST_OFF: begin
        if (s_r.ctrl[bcc_pkg::BIT_BOOST_EN] && !s_r.enPrev &&
            s_r.ctrl[bcc_pkg::BIT_ACTIVE]) begin
          s_nxt.st = bcc_pkg::ST_SOFT;
          s_nxt.softCnt = '0;
        end
      end
      bcc_pkg::ST_SOFT: begin
        if (s_r.softCnt == 22'(bcc_pkg::SOFT_CYC - 1))
          s_nxt.st = bcc_pkg::ST_RUN;
        else
          s_nxt.softCnt = s_r.softCnt + 22'h1;
      end
      bcc_pkg::ST_RUN: s_nxt.st = bcc_pkg::ST_RUN;
      default: s_nxt.st = bcc_pkg::ST_OFF;
    endcase
    // standby on enable low; device standby
    if (!s_nxt.ctrl[bcc_pkg::BIT_BOOST_EN] ||
        !s_nxt.ctrl[bcc_pkg::BIT_ACTIVE])
      s_nxt.st = bcc_pkg::ST_OFF;
    if (s_r.st == bcc_pkg::ST_OFF)
      s_nxt.softCnt = '0;
    // adaptive headroom step every ADJ_CYC cycles
    if (s_r.adjCnt == 10'(bcc_pkg::ADJ_CYC - 1)) begin
      s_nxt.adjCnt = '0;
      if (|ledEnable && lowMv < winLo &&
          s_r.adaptV < 5'(bcc_pkg::CODE_MAX))
        s_nxt.adaptV = s_r.adaptV + 5'h01;
      else if (|ledEnable && lowMv > winHi &&
               s_r.adaptV > 5'(bcc_pkg::CODE_MIN))
        s_nxt.adaptV = s_r.adaptV - 5'h01;
    end else begin
      s_nxt.adjCnt = s_r.adjCnt + 10'h001;
    end
    if (s_r.adaptV < 5'(bcc_pkg::CODE_MIN))
      s_nxt.adaptV = 5'(bcc_pkg::CODE_MIN);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r.volt    <= bcc_pkg::VOLT_RST;
      s_r.ctrl    <= bcc_pkg::CTRL_RST;
      s_r.enPrev  <= 1'b0;
      s_r.st      <= bcc_pkg::ST_OFF;
      s_r.softCnt <= '0;
      s_r.adjCnt  <= '0;
      s_r.adaptV  <= 5'(bcc_pkg::CODE_MIN);
      s_r.rdata   <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign running = s_r.st != bcc_pkg::ST_OFF;

  // manual target; code ignored when adaptive
  assign targetVolts = adaptive ? s_r.adaptV : codeUsed[4:0];

  bcc_pwm u_pwm (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .run            (running),
    .minPulseEn     (s_r.ctrl[bcc_pkg::BIT_ACTLOAD]),
    .lowCurrent     (s_r.st == bcc_pkg::ST_SOFT),
    .demandOff      (!feedbackSenseBelow),
    .overCurrent    (overCurrent),
    .feedbackBroken (feedbackBroken),
    .switchGate     (gate),
    .cycleStart     (cycStart)
  );

  assign powerSwitchGate  = gate;
  assign activeLoadOn     = running && s_r.ctrl[bcc_pkg::BIT_ACTLOAD];
  assign softStartActive  = s_r.st == bcc_pkg::ST_SOFT;
  assign converterRunning = running;
  assign deviceActive     = s_r.ctrl[bcc_pkg::BIT_ACTIVE];
  assign regRdata         = s_r.rdata;
endmodule : bcc_boost_converter_control

// ### bcc_checker_assertions.sv
// port checks for the boost converter control block
`timescale 1ns/10ps
module bcc_checker (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       regWrite,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       overCurrent,
  input wire logic       feedbackBroken,
  input wire logic       powerSwitchGate,
  input wire logic       activeLoadOn,
  input wire logic [4:0] targetVolts,
  input wire logic       softStartActive,
  input wire logic       converterRunning,
  input wire logic       deviceActive
);
  logic [7:0] hiCnt_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence ctrlWr;
    regWrite && regAddr == bcc_pkg::ADDR_CTRL;
  endsequence
  // consecutive high cycles of the switch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) hiCnt_r <= 8'h00;
    else hiCnt_r <= powerSwitchGate ? hiCnt_r + 8'h01 : 8'h00;
  end
  load_off_a: assert property (
    (ctrlWr ##0 !regWdata[3]) |=> !activeLoadOn) else $error("load on");
  dev_active_a: assert property (
    ctrlWr |=> deviceActive == $past(regWdata[0])) else $error("active");
  conv_standby_a: assert property (
    (ctrlWr ##0 !regWdata[1]) |=> !converterRunning) else $error("run");
  soft_first_a: assert property (
    $rose(converterRunning) |-> softStartActive) else $error("soft");
  oc_off_a: assert property (
    overCurrent |=> !powerSwitchGate) else $error("overcurrent");
  fb_off_a: assert property (
    feedbackBroken |=> !powerSwitchGate) else $error("feedback");
  idle_gate_a: assert property (
    !converterRunning |=> !powerSwitchGate) else $error("idle gate");
  target_range_a: assert property (
    targetVolts inside {[5'd5:5'd20]}) else $error("target range");
  duty_limit_a: assert property (
    hiCnt_r <= (softStartActive ? 8'd12 : 8'd46)) else $error("duty");
endmodule : bcc_checker
bind bcc_boost_converter_control bcc_checker u_chk (.sys_clk, .rst,
  .regWrite, .regAddr, .regWdata, .overCurrent, .feedbackBroken,
  .powerSwitchGate, .activeLoadOn, .targetVolts, .softStartActive,
  .converterRunning, .deviceActive);

// ### bcc_host.sv
// host model writing and reading the control registers
`timescale 1ns/10ps
module bcc_host (
  input  wire logic       sys_clk,
  output logic            regWrite,
  output logic      [6:0] regAddr,
  output logic      [7:0] regWdata,
  input  wire logic [7:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regAddr  = 7'h00;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
    regWdata = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    @(negedge sys_clk);
    d = regRdata;
  endtask : rd
endmodule : bcc_host

// ### bcc_pkg.sv
// constants for the boost converter control block
package bcc_pkg;
  localparam logic [6:0] ADDR_VOLT     = 7'h05;
  localparam logic [6:0] ADDR_CTRL     = 7'h06;
  localparam int         BIT_ACTLOAD   = 3;
  localparam int         BIT_ADAPT     = 2;
  localparam int         BIT_BOOST_EN  = 1;
  localparam int         BIT_ACTIVE    = 0;
  localparam logic [7:0] VOLT_RST      = 8'h14;
  localparam logic [7:0] CTRL_RST      = 8'h04;
  localparam logic [7:0] CODE_MIN      = 8'h05;
  localparam logic [7:0] CODE_MAX      = 8'h14;
  localparam int         CLK_HZ        = 50000000;
  localparam int         SW_HZ         = 1000000;
  localparam int         PERIOD_CYC    = CLK_HZ / SW_HZ;
  localparam int         MINPULSE_NS   = 50;
  localparam int         CLK_NS        = 20;
  localparam int         MINPULSE_CYC  = (MINPULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int         MAXDUTY_PCT   = 90;
  localparam int         MAXDUTY_CYC   = PERIOD_CYC * MAXDUTY_PCT / 100;
  localparam int         SOFT_MS       = 50;
  localparam int         SOFT_CYC      = SOFT_MS * (CLK_HZ / 1000);
  localparam int         ADJ_CYC       = 1000;
  // headroom window limits in millivolts
  localparam logic [11:0] WIN_LO_LOW   = 12'd850;
  localparam logic [11:0] WIN_HI_LOW   = 12'd1350;
  localparam logic [11:0] WIN_LO_HIGH  = 12'd1000;
  localparam logic [11:0] WIN_HI_HIGH  = 12'd1500;
  localparam logic [11:0] MV_MAX       = 12'hFFF;
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_SOFT = 2'b01,
    ST_RUN  = 2'b11
  } bcc_state_t;
endpackage : bcc_pkg

// ### bcc_pwm.sv
// fixed-frequency switching cycle generator with pulse limits
`timescale 1ns/10ps
module bcc_pwm (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       minPulseEn,
  input  wire logic       lowCurrent,
  input  wire logic       demandOff,
  input  wire logic       overCurrent,
  input  wire logic       feedbackBroken,
  output logic            switchGate,
  output logic            cycleStart
);
  typedef struct packed {
    logic [5:0] cnt;
    logic       gate;
    logic       start;
  } bcc_pwm_st_t;
  bcc_pwm_st_t s_r;
  bcc_pwm_st_t s_nxt;
  logic [5:0] limit;

  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    limit = lowCurrent ? 6'(bcc_pkg::MAXDUTY_CYC / 4)
                       : 6'(bcc_pkg::MAXDUTY_CYC);
    if (!run || feedbackBroken) begin
      s_nxt.cnt = 6'h00;
      s_nxt.gate = 1'b0;
    end else begin
      if (s_r.cnt == 6'(bcc_pkg::PERIOD_CYC - 1)) begin
        s_nxt.cnt = 6'h00;
        s_nxt.start = 1'b1;
        s_nxt.gate = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 6'h01;
      end
      if (s_r.gate && demandOff &&
          (!minPulseEn || s_r.cnt >= 6'(bcc_pkg::MINPULSE_CYC - 1)))
        s_nxt.gate = 1'b0;
      if (s_r.gate && !minPulseEn && demandOff && s_nxt.start)
        s_nxt.gate = 1'b0;
      if (s_r.cnt >= limit && !s_nxt.start)
        s_nxt.gate = 1'b0;
      if (overCurrent)
        s_nxt.gate = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign switchGate = s_r.gate;
  assign cycleStart = s_r.start;
endmodule : bcc_pwm

// ### tb.sv
// testbench for the boost converter control block
`timescale 1ns/10ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin \
  mismatches++; $display("Error t=%0t got %0h exp %0h", $time, g, e); \
  end end
module tb;
  logic sys_clk, rst, regWrite, standAlone, feedbackSenseBelow;
  logic feedbackBroken, overCurrent, powerSwitchGate, activeLoadOn;
  logic softStartActive, converterRunning, deviceActive;
  logic [6:0] regAddr;
  logic [7:0] regWdata, regRdata, d;
  logic [2:0] ledEnable, ledHighCurrent;
  logic [11:0] driverMv0, driverMv1, driverMv2;
  logic [4:0] targetVolts;
  int mismatches, checkCount, n;
  logic [7:0] codes [5] = '{8'h00, 8'h05, 8'h0C, 8'h14, 8'hFF};
  logic [4:0] volts [5] = '{5'd5, 5'd5, 5'd12, 5'd20, 5'd20};
  bcc_host host (.sys_clk, .regWrite, .regAddr, .regWdata, .regRdata);
  bcc_boost_converter_control i_bcc_boost_converter_control (.sys_clk,
    .rst, .regWrite, .regAddr, .regWdata, .regRdata, .standAlone,
    .ledEnable, .ledHighCurrent, .driverMv0, .driverMv1, .driverMv2,
    .feedbackSenseBelow, .feedbackBroken, .overCurrent, .powerSwitchGate,
    .activeLoadOn, .targetVolts, .softStartActive, .converterRunning,
    .deviceActive);
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic gateRise(output int k);
    k = 0;
    while (powerSwitchGate !== 1'b0 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    while (powerSwitchGate !== 1'b1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
  endtask : gateRise
  initial begin
    #(40000 * 20);
    mismatches++;
    stop_test();
  end
  initial begin
    {standAlone, ledEnable, ledHighCurrent, feedbackBroken} = '0;
    {overCurrent, mismatches, checkCount} = '0;
    feedbackSenseBelow = 1'b1;
    {driverMv0, driverMv1, driverMv2} = {12'd500, 12'd900, 12'd900};
    rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    `CHK(targetVolts, 5'd5)
    host.rd(bcc_pkg::ADDR_VOLT, d);
    `CHK(d, bcc_pkg::VOLT_RST)
    host.rd(bcc_pkg::ADDR_CTRL, d);
    `CHK(d, bcc_pkg::CTRL_RST)
    host.wr(bcc_pkg::ADDR_CTRL, 8'hF0);
    host.rd(bcc_pkg::ADDR_CTRL, d);
    `CHK(d, 8'h00)
    host.rd(7'h07, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 5; i++) begin
      host.wr(bcc_pkg::ADDR_VOLT, codes[i]);
      `CHK(targetVolts, volts[i])
    end
    host.wr(bcc_pkg::ADDR_VOLT, 8'h0C);
    standAlone = 1'b1;
    @(negedge sys_clk);
    `CHK(targetVolts, 5'd5)
    standAlone = 1'b0;
    host.wr(bcc_pkg::ADDR_CTRL, 8'h04);
    `CHK(targetVolts, 5'd5)
    host.wr(bcc_pkg::ADDR_CTRL, 8'h0F);
    repeat (2) @(negedge sys_clk);
    `CHK(softStartActive, 1'b1)
    `CHK(activeLoadOn, 1'b1)
    `CHK(deviceActive, 1'b1)
    gateRise(n);
    gateRise(n);
    `CHK(n, bcc_pkg::PERIOD_CYC)
    ledEnable = 3'b110;
    repeat (2500) @(negedge sys_clk);
    `CHK(targetVolts, 5'd5)
    ledHighCurrent = 3'b010;
    repeat (2500) @(negedge sys_clk);
    `CHK(targetVolts > 5'd5, 1'b1)
    overCurrent = 1'b1;
    repeat (60) @(negedge sys_clk);
    `CHK(powerSwitchGate, 1'b0)
    {overCurrent, feedbackBroken} = 2'b01;
    repeat (60) @(negedge sys_clk);
    `CHK(powerSwitchGate, 1'b0)
    // no load left, so the host stops the converter
    ledEnable = 3'b000;
    host.wr(bcc_pkg::ADDR_CTRL, 8'h0D);
    repeat (2) @(negedge sys_clk);
    `CHK(converterRunning, 1'b0)
    `CHK(activeLoadOn, 1'b0)
    host.wr(bcc_pkg::ADDR_CTRL, 8'h00);
    `CHK(deviceActive, 1'b0)
    stop_test();
  end
endmodule : tb
